/* design/rrb_backup.v */
// Purpose: counter/data register keep-clear at startup and data register backup to non-volatile memory
// Assumes: scan logic, register port and backup memory port all run on clk_sys; cartridge detect is a pin
// Notes: counter and data register arrays live here and have no reset, so they survive rst_n
`include "rrb_defs.vh"
module rrb_backup (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // register port
    input wire [11:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata_r,
    // scan logic
    input wire runStart,
    input wire scanEnd,
    output wire busy,
    // backup memory port
    output reg nvReq_r,
    output reg nvWe_r,
    output reg nvSel_r,
    output reg [10:0] nvAddr_r,
    output reg [15:0] nvWdata_r,
    input wire nvAck,
    input wire nvErr,
    input wire [15:0] nvRdata,
    // cartridge detect pin
    input wire cartPresent
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_CLR = 4'h1;
    localparam [3:0] S_WBEG = 4'h2;
    localparam [3:0] S_WMK0 = 4'h3;
    localparam [3:0] S_WDAT = 4'h4;
    localparam [3:0] S_WMK1 = 4'h5;
    localparam [3:0] S_WMKW = 4'h6;
    localparam [3:0] S_RCHK = 4'h7;
    localparam [3:0] S_RMK = 4'h8;
    localparam [3:0] S_RDAT = 4'h9;
    localparam [3:0] S_DONE = 4'hA;

    reg [15:0] dmem [0:`RRB_DREGS-1];
    reg [15:0] cmem [0:`RRB_CNTS-1];
    reg [3:0] state_r;
    reg [2:0] status_r;
    reg [2:0] res_r;
    reg [15:0] start_r;
    reg [15:0] count_r;
    reg wrTrig_r;
    reg rdTrig_r;
    reg [1:0] cMode_r;
    reg [1:0] dMode_r;
    reg small_r;
    reg [7:0] cFirst_r;
    reg [7:0] cLast_r;
    reg [10:0] dFirst_r;
    reg [10:0] dLast_r;
    reg [10:0] idx_r;
    reg [10:0] dst_r;
    reg [11:0] rdEnd_r;
    reg cartMeta_r;
    reg cartSync_r;
    wire [10:0] maxIdx;
    wire [16:0] rdSum;
    wire rangeBad;
    wire romAvail;
    wire ackOk;
    wire ackBad;
    wire busCWr;
    wire busDWr;
    wire isCWin;
    wire isDWin;
    wire clrC;
    wire clrD;
    wire fifoInValid;
    wire [15:0] fifoInData;
    wire fifoInReady;
    wire fifoOutValid;
    wire [15:0] fifoOutData;
    wire fifoOutReady;
    wire fifoFlush;
    wire wrIssue;
    wire rdIssue;
    wire drainPop;
    wire nextAfterWrite;

    // cartridge detect arrives from a pin, two stages before use
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cartMeta_r <= 1'b0;
            cartSync_r <= 1'b0;
        end else begin
            cartMeta_r <= cartPresent;
            cartSync_r <= cartMeta_r;
        end
    end

    assign maxIdx = small_r ? `RRB_DMAX_SMALL : `RRB_DMAX_LARGE;
    assign romAvail = cartSync_r || !small_r;
    assign rdSum = {1'b0, start_r} + {1'b0, count_r};
    assign rangeBad = (count_r == 16'h0000) || (start_r > {5'h00, maxIdx})
        || (rdSum > ({6'h00, maxIdx} + 17'h00001));
    assign ackOk = nvReq_r && nvAck && !nvErr;
    assign ackBad = nvReq_r && nvAck && nvErr;
    assign busy = (state_r != S_IDLE);
    assign nextAfterWrite = rdTrig_r;

    // array windows on the register port
    assign isCWin = (regAddr[11:8] == `RRB_CWIN_TAG) && ({3'h0, regAddr[7:0]} <= `RRB_CMAX);
    assign isDWin = (regAddr[11] == `RRB_DWIN_TAG) && (regAddr[10:0] <= `RRB_DMAX_LARGE);
    assign busCWr = regWr && isCWin;
    assign busDWr = regWr && isDWin;

    // clear only during the start sweep
    assign clrC = (state_r == S_CLR) && (idx_r <= `RRB_CMAX)
        && ((cMode_r == `RRB_MODE_ALL)
        || ((cMode_r == `RRB_MODE_RANGE) && (idx_r[7:0] >= cFirst_r) && (idx_r[7:0] <= cLast_r)));
    assign clrD = (state_r == S_CLR)
        && ((dMode_r == `RRB_MODE_ALL)
        || ((dMode_r == `RRB_MODE_RANGE) && (idx_r >= dFirst_r) && (idx_r <= dLast_r)));

    // staging buffer steering: registers to memory on write, memory to registers on read
    assign fifoInValid = ((state_r == S_WDAT) && (idx_r <= maxIdx)) || ((state_r == S_RDAT) && ackOk);
    assign fifoInData = (state_r == S_RDAT) ? nvRdata : dmem[idx_r];
    assign wrIssue = (state_r == S_WDAT) && !nvReq_r && fifoOutValid;
    // one read in flight at most, issued only with room for its answer
    assign rdIssue = (state_r == S_RDAT) && !nvReq_r && ({1'b0, idx_r} < rdEnd_r) && fifoInReady;
    // restore drain yields to a software write of the data array
    assign drainPop = (state_r == S_RDAT) && fifoOutValid && !busDWr;
    assign fifoOutReady = wrIssue || drainPop;
    assign fifoFlush = ackBad;

    rrb_fifo #(
        .WIDTH(16),
        .DEPTH(`RRB_FIFO_DEPTH),
        .AW(`RRB_FIFO_AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(fifoFlush),
        .inValid(fifoInValid),
        .inData(fifoInData),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(fifoOutReady)
    );

    // data array: start sweep first, then restore drain, then software
    always @(posedge clk_sys) begin
        if (clrD) begin
            dmem[idx_r] <= 16'h0000;
        end else if (drainPop) begin
            dmem[dst_r] <= fifoOutData;
        end else if (busDWr && (state_r != S_CLR)) begin
            // kept values change only by software or the restore drain
            dmem[regAddr[10:0]] <= regWdata;
        end
    end

    // counter array
    always @(posedge clk_sys) begin
        if (clrC) begin
            cmem[idx_r[7:0]] <= 16'h0000;
        end else if (busCWr && (state_r != S_CLR)) begin
            // kept counters untouched by the sweep
            cmem[regAddr[7:0]] <= regWdata;
        end
    end

    // trigger flags: software sets, engine clears; a set in the clear cycle wins
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrTrig_r <= 1'b0;
            rdTrig_r <= 1'b0;
        end else begin
            if (state_r == S_DONE) begin
                wrTrig_r <= 1'b0;
                rdTrig_r <= 1'b0;
            end else if ((state_r == S_IDLE) && runStart) begin
                wrTrig_r <= 1'b0;
                rdTrig_r <= 1'b0;
            end
            if (regWr && (regAddr == `RRB_ADDR_CTRL)) begin
                if (regWdata[`RRB_CTRL_WR]) begin
                    wrTrig_r <= 1'b1;
                end else if (state_r == S_IDLE && !runStart) begin
                    wrTrig_r <= 1'b0;
                end
                if (regWdata[`RRB_CTRL_RD]) begin
                    rdTrig_r <= 1'b1;
                end else if (state_r == S_IDLE && !runStart) begin
                    rdTrig_r <= 1'b0;
                end
            end
        end
    end

    // configuration and read arguments
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cMode_r <= `RRB_MODE_KEEP;
            dMode_r <= `RRB_MODE_KEEP;
            small_r <= 1'b0;
            cFirst_r <= 8'h00;
            cLast_r <= 8'h00;
            dFirst_r <= 11'h000;
            dLast_r <= 11'h000;
            start_r <= 16'h0000;
            count_r <= 16'h0000;
        end else if ((state_r == S_IDLE) && runStart) begin
            start_r <= 16'h0000;
            count_r <= 16'h0000;
        end else if (regWr) begin
            case (regAddr)
                `RRB_ADDR_START: start_r <= regWdata;
                `RRB_ADDR_COUNT: count_r <= regWdata;
                `RRB_ADDR_CFG: begin
                    cMode_r <= regWdata[`RRB_CFG_CMODE_LO+1:`RRB_CFG_CMODE_LO];
                    dMode_r <= regWdata[`RRB_CFG_DMODE_LO+1:`RRB_CFG_DMODE_LO];
                    small_r <= regWdata[`RRB_CFG_SMALL];
                end
                `RRB_ADDR_CFIRST: cFirst_r <= regWdata[7:0];
                `RRB_ADDR_CLAST: cLast_r <= regWdata[7:0];
                `RRB_ADDR_DFIRST: dFirst_r <= regWdata[10:0];
                `RRB_ADDR_DLAST: dLast_r <= regWdata[10:0];
                default: ;
            endcase
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_r <= 16'h0000;
        end else if (regRd) begin
            if (isDWin) begin
                regRdata_r <= dmem[regAddr[10:0]];
            end else if (isCWin) begin
                regRdata_r <= cmem[regAddr[7:0]];
            end else begin
                case (regAddr)
                    `RRB_ADDR_STATUS: regRdata_r <= {13'h0000, status_r};
                    `RRB_ADDR_START: regRdata_r <= start_r;
                    `RRB_ADDR_COUNT: regRdata_r <= count_r;
                    `RRB_ADDR_CTRL: regRdata_r <= {14'h0000, rdTrig_r, wrTrig_r};
                    `RRB_ADDR_CFG: regRdata_r <= {11'h000, small_r, dMode_r, cMode_r};
                    `RRB_ADDR_CFIRST: regRdata_r <= {8'h00, cFirst_r};
                    `RRB_ADDR_CLAST: regRdata_r <= {8'h00, cLast_r};
                    `RRB_ADDR_DFIRST: regRdata_r <= {5'h00, dFirst_r};
                    `RRB_ADDR_DLAST: regRdata_r <= {5'h00, dLast_r};
                    default: regRdata_r <= 16'h0000;
                endcase
            end
        end
    end

    // sequencer: start sweep, backup write, restore read
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            status_r <= `RRB_ST_NONE;
            res_r <= `RRB_ST_NONE;
            idx_r <= 11'h000;
            dst_r <= 11'h000;
            rdEnd_r <= 12'h000;
            nvReq_r <= 1'b0;
            nvWe_r <= 1'b0;
            nvSel_r <= 1'b0;
            nvAddr_r <= 11'h000;
            nvWdata_r <= 16'h0000;
        end else begin
            // a request drops the cycle after its answer
            if (nvReq_r && nvAck) begin
                nvReq_r <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    if (runStart) begin
                        status_r <= `RRB_ST_NONE;
                        idx_r <= 11'h000;
                        state_r <= S_CLR;
                    end else if (scanEnd && (wrTrig_r || rdTrig_r)) begin
                        status_r <= `RRB_ST_BUSY;
                        nvSel_r <= cartSync_r;
                        state_r <= wrTrig_r ? S_WBEG : S_RCHK;
                    end
                end
                S_CLR: begin
                    idx_r <= idx_r + 11'h001;
                    if (idx_r == `RRB_DMAX_LARGE) begin
                        state_r <= S_IDLE;
                    end
                end
                S_WBEG: begin
                    if (!romAvail) begin
                        res_r <= `RRB_ST_NOROM;
                        state_r <= nextAfterWrite ? S_RCHK : S_DONE;
                    end else begin
                        // invalidate the image first so a cut write reads back as empty
                        nvReq_r <= 1'b1;
                        nvWe_r <= 1'b1;
                        nvAddr_r <= `RRB_MARK_ADDR;
                        nvWdata_r <= `RRB_MARK_EMPTY;
                        state_r <= S_WMK0;
                    end
                end
                S_WMK0: begin
                    if (ackBad) begin
                        res_r <= `RRB_ST_NOROM;
                        state_r <= nextAfterWrite ? S_RCHK : S_DONE;
                    end else if (ackOk) begin
                        idx_r <= 11'h000;
                        dst_r <= 11'h000;
                        state_r <= S_WDAT;
                    end
                end
                S_WDAT: begin
                    if (fifoInValid && fifoInReady) begin
                        idx_r <= idx_r + 11'h001;
                    end
                    if (wrIssue) begin
                        nvReq_r <= 1'b1;
                        nvWe_r <= 1'b1;
                        nvAddr_r <= dst_r;
                        nvWdata_r <= fifoOutData;
                    end
                    if (ackBad) begin
                        res_r <= `RRB_ST_NOROM;
                        state_r <= nextAfterWrite ? S_RCHK : S_DONE;
                    end else if (ackOk) begin
                        dst_r <= dst_r + 11'h001;
                        if (dst_r == maxIdx) begin
                            state_r <= S_WMK1;
                        end
                    end
                end
                S_WMK1: begin
                    nvReq_r <= 1'b1;
                    nvWe_r <= 1'b1;
                    nvAddr_r <= `RRB_MARK_ADDR;
                    nvWdata_r <= `RRB_MARK_VALID;
                    state_r <= S_WMKW;
                end
                S_WMKW: begin
                    if (nvReq_r && nvAck) begin
                        res_r <= nvErr ? `RRB_ST_NOROM : `RRB_ST_OK;
                        state_r <= nextAfterWrite ? S_RCHK : S_DONE;
                    end
                end
                S_RCHK: begin
                    if (rangeBad) begin
                        res_r <= `RRB_ST_BADARG;
                        state_r <= S_DONE;
                    end else if (!romAvail) begin
                        res_r <= `RRB_ST_NOROM;
                        state_r <= S_DONE;
                    end else begin
                        nvReq_r <= 1'b1;
                        nvWe_r <= 1'b0;
                        nvAddr_r <= `RRB_MARK_ADDR;
                        state_r <= S_RMK;
                    end
                end
                S_RMK: begin
                    if (ackBad) begin
                        res_r <= `RRB_ST_NOROM;
                        state_r <= S_DONE;
                    end else if (ackOk) begin
                        if (nvRdata != `RRB_MARK_VALID) begin
                            res_r <= `RRB_ST_NODATA;
                            state_r <= S_DONE;
                        end else begin
                            idx_r <= start_r[10:0];
                            dst_r <= start_r[10:0];
                            rdEnd_r <= rdSum[11:0];
                            state_r <= S_RDAT;
                        end
                    end
                end
                S_RDAT: begin
                    if (rdIssue) begin
                        nvReq_r <= 1'b1;
                        nvWe_r <= 1'b0;
                        nvAddr_r <= idx_r;
                        idx_r <= idx_r + 11'h001;
                    end
                    if (drainPop) begin
                        dst_r <= dst_r + 11'h001;
                    end
                    if (ackBad) begin
                        res_r <= `RRB_ST_NOROM;
                        state_r <= S_DONE;
                    end else if (drainPop && ({1'b0, dst_r} + 12'h001 == rdEnd_r)) begin
                        res_r <= `RRB_ST_OK;
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    status_r <= res_r;
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule // rrb_backup

/* design/rrb_defs.vh */
// Purpose: shared constants of the retention and backup block
// Assumes: included by rrb_backup.v, not by rrb_fifo.v
// Notes: register offsets are word indices on the plain register port
`ifndef RRB_DEFS_VH
`define RRB_DEFS_VH

// register offsets
`define RRB_ADDR_STATUS 12'h000
`define RRB_ADDR_START 12'h001
`define RRB_ADDR_COUNT 12'h002
`define RRB_ADDR_CTRL 12'h003
`define RRB_ADDR_CFG 12'h004
`define RRB_ADDR_CFIRST 12'h005
`define RRB_ADDR_CLAST 12'h006
`define RRB_ADDR_DFIRST 12'h007
`define RRB_ADDR_DLAST 12'h008
// windows onto the counter and data register arrays
`define RRB_CWIN_TAG 4'h4
`define RRB_DWIN_TAG 1'h1

// field positions
`define RRB_CTRL_WR 0
`define RRB_CTRL_RD 1
`define RRB_CFG_CMODE_LO 0
`define RRB_CFG_DMODE_LO 2
`define RRB_CFG_SMALL 4

// keep/clear modes, reset value is keep all
`define RRB_MODE_KEEP 2'h0
`define RRB_MODE_ALL 2'h1
`define RRB_MODE_RANGE 2'h2

// status codes
`define RRB_ST_NONE 3'h0
`define RRB_ST_BUSY 3'h1
`define RRB_ST_OK 3'h2
`define RRB_ST_NOROM 3'h3
`define RRB_ST_BADARG 3'h4
`define RRB_ST_NODATA 3'h5

// array sizes and limits
`define RRB_DMAX_SMALL 11'h18F
`define RRB_DMAX_LARGE 11'h7CF
`define RRB_CMAX 11'h0C7
`define RRB_DREGS 2000
`define RRB_CNTS 200

// image marker, stored after the last data word
`define RRB_MARK_ADDR 11'h7D0
`define RRB_MARK_VALID 16'hA5C3
`define RRB_MARK_EMPTY 16'h0000

// staging buffer
`define RRB_FIFO_DEPTH 8
`define RRB_FIFO_AW 3

`endif

/* design/rrb_fifo.v */
// Purpose: small staging FIFO between data registers and backup memory
// Assumes: DEPTH is a power of two equal to 2**AW
// Notes: flush empties it in one cycle, used when a transfer aborts
module rrb_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire flush,
    // filling side
    input wire inValid,
    input wire [WIDTH-1:0] inData,
    output wire inReady,
    // draining side
    output wire outValid,
    output wire [WIDTH-1:0] outData,
    input wire outReady
);
    localparam [AW:0] FULL = DEPTH;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_r;
    reg [AW:0] rdPtr_r;
    wire [AW:0] fill;
    wire doPush;
    wire doPop;

    // extra pointer bit tells full from empty without a counter
    assign fill = wrPtr_r - rdPtr_r;
    assign inReady = (fill != FULL);
    assign outValid = (fill != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_r[AW-1:0]];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    // storage
    always @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end

    // pointers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= {(AW+1){1'b0}};
            rdPtr_r <= {(AW+1){1'b0}};
        end else if (flush) begin
            wrPtr_r <= {(AW+1){1'b0}};
            rdPtr_r <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtr_r <= wrPtr_r + {{AW{1'b0}}, 1'b1};
            end
            if (doPop) begin
                rdPtr_r <= rdPtr_r + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // rrb_fifo

/* testbench/rrb_chk.sv */
// Purpose: port assertions for rrb_backup
// Assumes: one clock domain
// Notes: array contents are judged by the bench
module rrb_chk (
    // watched ports
    input wire clk_sys, rst_n, runStart, busy, nvReq_r, nvWe_r, nvSel_r, nvAck, nvErr,
    input wire [10:0] nvAddr_r,
    input wire [15:0] nvWdata_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // the first 8 cycles of the sweep work alone, memory stays quiet
    sequence s_sweep; (busy && !nvReq_r) [*8]; endsequence
    property p_ack; nvAck |=> !nvReq_r; endproperty
    a_ack: assert property (p_ack) else $error("request held after ack");
    property p_hold; nvReq_r && !nvAck |=> nvReq_r && $stable(nvAddr_r) && $stable(nvWe_r) && $stable(nvWdata_r); endproperty
    a_hold: assert property (p_hold) else $error("request moved before ack");
    property p_busy; nvReq_r |-> busy; endproperty
    a_busy: assert property (p_busy) else $error("request while idle");
    property p_max; nvReq_r |-> nvAddr_r <= 11'h7D0; endproperty
    a_max: assert property (p_max) else $error("address past image");
    property p_sweep; runStart && !busy |=> s_sweep; endproperty
    a_sweep: assert property (p_sweep) else $error("sweep not started");
    property p_abort; nvAck && nvErr |-> ##[1:16] !busy; endproperty
    a_abort: assert property (p_abort) else $error("no abort on error");
    property p_sel; busy && $past(busy) |-> $stable(nvSel_r); endproperty
    a_sel: assert property (p_sel) else $error("target changed mid transfer");
    property p_mark; nvReq_r && nvWe_r && nvAddr_r == 11'h7D0 |-> nvWdata_r == 16'h0000 || nvWdata_r == 16'hA5C3;
    endproperty
    a_mark: assert property (p_mark) else $error("bad marker value");
endmodule // rrb_chk

/* testbench/rrb_mem_model.sv */
// Purpose: backup memory seen from rrb_backup
// Assumes: one request at a time
// Notes: stalls 0 to 2 cycles; released read data toggles each cycle
module rrb_mem_model (
    // request side
    input wire logic clk_sys, nvReq_r, nvWe_r, failNext,
    input wire logic [10:0] nvAddr_r,
    input wire logic [15:0] nvWdata_r,
    // answer side
    output logic nvAck, nvErr,
    output logic [15:0] nvRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:2000];
    int stall = 0;
    // blank memory holds no image
    initial begin
        {nvAck, nvErr, nvRdata} = '0;
        mem[2000] = 16'h0000;
    end
    // one answer per request; a failed write leaves the cell alone
    always @(posedge clk_sys) begin
        nvAck <= 1'b0;
        nvErr <= 1'b0;
        nvRdata <= ~nvRdata;
        if (nvReq_r && !nvAck && stall > 0) stall <= stall - 1;
        else if (nvReq_r && !nvAck) begin
            {nvAck, nvErr} <= {1'b1, failNext};
            stall <= $urandom % 3;
            if (!nvWe_r) nvRdata <= mem[nvAddr_r];
            else if (!failNext) mem[nvAddr_r] <= nvWdata_r;
        end
    end
endmodule // rrb_mem_model

/* testbench/test_rrb_backup.sv */
// Purpose: self-checking bench for rrb_backup
// Assumes: read data checked the cycle after the strobe
// Notes: sweeps take 2000 cycles, so few are run
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_rrb_backup;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_n, regWr, regRd, runStart, scanEnd, cartPresent, failNext, rdSeen, selBad;
    logic busy, nvReq_r, nvWe_r, nvSel_r, nvAck, nvErr;
    logic [11:0] regAddr;
    logic [10:0] nvAddr_r;
    logic [15:0] regWdata, regRdata_r, nvWdata_r, nvRdata;
    logic [15:0] v [8];
    logic [11:0] ca [4] = '{12'h404, 12'h405, 12'h40A, 12'h40B};
    logic [31:0] sc [4] = '{32'h0000_0000, 32'h07D0_0001, 32'h07CF_0002, 32'h0000_07D0};
    logic [27:0] expQ [$];
    int fail_count = 0;
    int check_count = 0;
    rrb_backup u_rrb_backup (.clk_sys, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata_r, .runStart,
        .scanEnd, .busy, .nvReq_r, .nvWe_r, .nvSel_r, .nvAddr_r, .nvWdata_r, .nvAck, .nvErr, .nvRdata, .cartPresent);
    rrb_mem_model u_rrb_mem_model (.clk_sys, .nvReq_r, .nvWe_r, .failNext, .nvAddr_r, .nvWdata_r, .nvAck, .nvErr,
        .nvRdata);
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // oldest note against the data standing after the strobe
    always @(posedge clk_sys) begin
        if (rdSeen === 1'b1) begin
            `CHK($sformatf("reg %h", expQ[0][27:16]), expQ[0][15:0], regRdata_r)
            void'(expQ.pop_front());
        end
        rdSeen <= regRd;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        {regAddr, regWdata, regWr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        {regAddr, regRd} <= {a, 1'b1};
        expQ.push_back({a, e});
        @(posedge clk_sys);
        regRd <= 1'b0;
    endtask
    // pulse start or end of scan, then wait for idle under a bound
    task automatic go(input logic s);
        @(posedge clk_sys);
        {scanEnd, runStart} <= {s, !s};
        @(posedge clk_sys);
        {scanEnd, runStart} <= 2'b00;
        for (int n = 0; busy !== 1'b0 || n == 0; n++) begin
            @(posedge clk_sys);
            if (nvReq_r === 1'b1 && nvSel_r !== cartPresent) selBad = 1'b1;
            if (n > 20000) begin
                fail_count++;
                complete_run();
            end
        end
    endtask
    task automatic trig(input logic [15:0] c, input logic [15:0] st);
        wr(12'h003, c);
        go(1'b1);
        rd(12'h000, st);
        rd(12'h003, 16'h0000);
    endtask
    task automatic args(input logic [31:0] p);
        wr(12'h001, p[31:16]);
        wr(12'h002, p[15:0]);
    endtask
    initial begin
        {rst_n, regWr, regRd, runStart, scanEnd, cartPresent, failNext, rdSeen, selBad} = '0;
        {regAddr, regWdata} = '0;
        void'($urandom(30913));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(ca[i], 16'(i + 1));
            wr(12'h802 + 12'(i), 16'(i + 5));
        end
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ca[3], 16'h0004);
        wr(12'h004, 16'h000A);
        wr(12'h001, 16'h0009);
        for (int i = 0; i < 4; i++) wr(12'h005 + 12'(i), 16'(i == 0 ? 5 : i == 1 ? 10 : i + 1));
        go(1'b0);
        for (int i = 0; i < 4; i++) begin
            rd(ca[i], i % 3 == 0 ? 16'(i + 1) : 16'h0000);
            rd(12'h802 + 12'(i), i % 3 == 0 ? 16'(i + 5) : 16'h0000);
        end
        rd(12'h001, 16'h0000);
        wr(12'h004, 16'h0005);
        go(1'b0);
        rd(ca[3], 16'h0000);
        rd(12'h805, 16'h0000);
        args(32'h0000_0001);
        trig(16'h0002, 16'h0005);
        wr(12'h000, 16'h0007);
        rd(12'h000, 16'h0005);
        rd(12'h00F, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            v[i] = 16'($urandom);
            wr(12'h800 + 12'(i), v[i]);
        end
        trig(16'h0001, 16'h0002);
        for (int i = 0; i < 8; i++) wr(12'h800 + 12'(i), ~v[i]);
        args(32'h0002_0003);
        trig(16'h0002, 16'h0002);
        for (int i = 0; i < 8; i++) rd(12'h800 + 12'(i), (i >= 2 && i <= 4) ? v[i] : ~v[i]);
        for (int i = 0; i < 4; i++) begin
            args(sc[i]);
            trig(16'h0002, i == 3 ? 16'h0002 : 16'h0004);
        end
        wr(12'h800, ~v[0]);
        args(32'h0000_0001);
        trig(16'h0003, 16'h0002);
        rd(12'h800, ~v[0]);
        cartPresent <= 1'b1;
        trig(16'h0001, 16'h0002);
        cartPresent <= 1'b0;
        wr(12'h004, 16'h0010);
        trig(16'h0002, 16'h0003);
        args(32'h0190_0001);
        trig(16'h0002, 16'h0004);
        wr(12'h004, 16'h0000);
        failNext <= 1'b1;
        trig(16'h0001, 16'h0003);
        `CHK("cartridge select", 1'b0, selBad)
        repeat (2) @(posedge clk_sys);
        complete_run();
    end
endmodule // test_rrb_backup
bind rrb_backup rrb_chk u_rrb_chk (.clk_sys, .rst_n, .runStart, .busy, .nvReq_r, .nvWe_r, .nvSel_r, .nvAck,
    .nvErr, .nvAddr_r, .nvWdata_r);
